// ### core/cmpc_pkg.sv
// shared constants for the comparator control and flag register
package cmpc_pkg;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR  = 8'h9a;  // special-function address
    localparam logic [7:0] CTRL_PAGE  = 8'h00;  // special-function page
    localparam logic [7:0] CTRL_RESET = 8'h00;  // every bit clears on reset

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ENABLE_BIT = 7;
    localparam int OUT_BIT    = 6;
    localparam int RISE_BIT   = 5;
    localparam int FALL_BIT   = 4;
    localparam int POS_HI     = 3;
    localparam int POS_LO     = 2;
    localparam int NEG_HI     = 1;
    localparam int NEG_LO     = 0;

    // ------------------------------------------------------------
    // hysteresis codes
    // ------------------------------------------------------------
    localparam logic [1:0] HYST_OFF   = 2'h0;  // disabled
    localparam logic [1:0] HYST_5MV   = 2'h1;
    localparam logic [1:0] HYST_10MV  = 2'h2;
    localparam logic [1:0] HYST_20MV  = 2'h3;

endpackage

// ### core/cmpc_edge_if.sv
// carrier for the synchronised comparator level and its edge pulses
`timescale 1ns/1ns
`default_nettype none

interface cmpc_edge_if;
    logic level;  // synchronised comparator result
    logic rise;   // one-cycle pulse on a rising transition
    logic fall;   // one-cycle pulse on a falling transition

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

`default_nettype wire

// ### core/cmpc_edge_detect.sv
// synchroniser and edge detector for the analog comparator result
`timescale 1ns/1ns
`default_nettype none

module cmpc_edge_detect (
    input  wire logic   clk,     // system clock
    input  wire logic   rst_n,   // asynchronous reset, active low
    input  wire logic   raw,     // comparator result, asynchronous
    cmpc_edge_if.src    edge_o   // level and edge pulses
);

    // ------------------------------------------------------------
    // two-flop synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    logic meta;
    logic sync;
    logic prev;

    // the analog result may change at any instant, so it is retimed first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
        end else begin
            meta <= raw;
            sync <= meta;
        end
    end

    // ------------------------------------------------------------
    // edge pulses, registered so downstream sees clean flops
    // ------------------------------------------------------------
    // no filtering: power-up and setting changes may yield false edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev        <= 1'b0;
            edge_o.rise <= 1'b0;
            edge_o.fall <= 1'b0;
        end else begin
            prev        <= sync;
            edge_o.rise <= sync & ~prev;
            edge_o.fall <= ~sync & prev;
        end
    end

    assign edge_o.level = sync;

endmodule

`default_nettype wire

// ### core/cmpc_control.sv
// comparator control register: enable, output state, edge flags, hysteresis
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - bit 6 reads live comparator result
// - bit 5 sticky rising-edge flag, software clears
// - bit 4 sticky falling-edge flag, software clears
// - bits 3:2 select positive hysteresis
// - bits 1:0 select negative hysteresis
// - edge flags may set spuriously; no filtering
// - register at address 0x9A page 0x00, resets zero
module cmpc_control (
    input  wire logic       MCLK,          // system clock, 20 MHz
    input  wire logic       RST_N,         // asynchronous reset, active low
    input  wire logic [7:0] SFR_ADDR,      // special-function address
    input  wire logic [7:0] SFR_PAGE,      // special-function page
    input  wire logic       SFR_WR,        // write strobe, one cycle
    input  wire logic       SFR_RD,        // read strobe, one cycle
    input  wire logic [7:0] SFR_WDATA,     // write data
    output logic      [7:0] SFR_RDATA,     // read data, valid a cycle after SFR_RD
    input  wire logic       CMP_RESULT,    // analog comparator result
    output logic            CMP_ENABLE,    // comparator power enable
    output logic      [1:0] CMP_POS_HYST,  // positive hysteresis code
    output logic      [1:0] CMP_NEG_HYST   // negative hysteresis code
);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    cmpc_edge_if cmp ();

    cmpc_edge_detect u_edge (
        .clk    (MCLK),
        .rst_n  (RST_N),
        .raw    (CMP_RESULT),
        .edge_o (cmp)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic addr_hit;
    logic wr_hit;
    logic rd_hit;
    logic rise_flag;
    logic fall_flag;
    logic [7:0] ctrl_view;

    // both address and page must match
    assign addr_hit = (SFR_ADDR == cmpc_pkg::CTRL_ADDR) && (SFR_PAGE == cmpc_pkg::CTRL_PAGE);
    assign wr_hit   = SFR_WR && addr_hit;
    assign rd_hit   = SFR_RD && addr_hit;

    // ------------------------------------------------------------
    // software-owned control fields
    // ------------------------------------------------------------
    // enable and hysteresis drive the analog block straight from flops
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CMP_ENABLE   <= cmpc_pkg::CTRL_RESET[cmpc_pkg::ENABLE_BIT];
            CMP_POS_HYST <= cmpc_pkg::HYST_OFF;
            CMP_NEG_HYST <= cmpc_pkg::HYST_OFF;
        end else if (wr_hit) begin
            CMP_ENABLE   <= SFR_WDATA[cmpc_pkg::ENABLE_BIT];
            CMP_POS_HYST <= SFR_WDATA[cmpc_pkg::POS_HI:cmpc_pkg::POS_LO];
            CMP_NEG_HYST <= SFR_WDATA[cmpc_pkg::NEG_HI:cmpc_pkg::NEG_LO];
        end
    end

    // ------------------------------------------------------------
    // sticky edge flags
    // ------------------------------------------------------------
    // an edge in the same cycle as a software clear wins, so no edge is lost
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rise_flag <= cmpc_pkg::CTRL_RESET[cmpc_pkg::RISE_BIT];
            fall_flag <= cmpc_pkg::CTRL_RESET[cmpc_pkg::FALL_BIT];
        end else begin
            if (cmp.rise) begin
                rise_flag <= 1'b1;
            end else if (wr_hit) begin
                rise_flag <= SFR_WDATA[cmpc_pkg::RISE_BIT];
            end
            if (cmp.fall) begin
                fall_flag <= 1'b1;
            end else if (wr_hit) begin
                fall_flag <= SFR_WDATA[cmpc_pkg::FALL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // output-state bit is read-only; writes to it are dropped
    assign ctrl_view = {CMP_ENABLE, cmp.level, rise_flag, fall_flag,
                        CMP_POS_HYST, CMP_NEG_HYST};

    // registered read data; idle bus reads as zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_RDATA <= 8'h00;
        end else if (rd_hit) begin
            SFR_RDATA <= ctrl_view;
        end else begin
            SFR_RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_wr_hit;
        SFR_WR && (SFR_ADDR == cmpc_pkg::CTRL_ADDR) && (SFR_PAGE == cmpc_pkg::CTRL_PAGE);
    endsequence

    sequence s_rd_hit;
        SFR_RD && (SFR_ADDR == cmpc_pkg::CTRL_ADDR) && (SFR_PAGE == cmpc_pkg::CTRL_PAGE);
    endsequence

    property p_out_state;
        @(posedge MCLK) disable iff (!RST_N)
        s_rd_hit |=> SFR_RDATA[cmpc_pkg::OUT_BIT] == $past(cmp.level);
    endproperty
    a_out_state: assert property (p_out_state) else $error("output state bit wrong");

    property p_rise_sticky;
        @(posedge MCLK) disable iff (!RST_N)
        (cmp.rise ##1 (!SFR_WR)[*2]) |-> rise_flag;
    endproperty
    a_rise_sticky: assert property (p_rise_sticky) else $error("rise flag lost");

    property p_fall_sticky;
        @(posedge MCLK) disable iff (!RST_N)
        (cmp.fall ##1 (!SFR_WR)[*2]) |-> fall_flag;
    endproperty
    a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag lost");

    property p_pos_hyst;
        @(posedge MCLK) disable iff (!RST_N)
        s_wr_hit |=> CMP_POS_HYST == $past(SFR_WDATA[cmpc_pkg::POS_HI:cmpc_pkg::POS_LO]);
    endproperty
    a_pos_hyst: assert property (p_pos_hyst) else $error("positive hysteresis not loaded");

    property p_neg_hyst;
        @(posedge MCLK) disable iff (!RST_N)
        s_wr_hit |=> CMP_NEG_HYST == $past(SFR_WDATA[cmpc_pkg::NEG_HI:cmpc_pkg::NEG_LO]);
    endproperty
    a_neg_hyst: assert property (p_neg_hyst) else $error("negative hysteresis not loaded");

    property p_spurious;
        @(posedge MCLK) disable iff (!RST_N)
        (cmp.rise && !CMP_ENABLE) |=> rise_flag;
    endproperty
    a_spurious: assert property (p_spurious) else $error("edge while disabled filtered");

    property p_decode;
        @(posedge MCLK) disable iff (!RST_N)
        (SFR_WR && !addr_hit) |=> $stable(CMP_ENABLE) && $stable(CMP_POS_HYST)
                                  && $stable(CMP_NEG_HYST);
    endproperty
    a_decode: assert property (p_decode) else $error("foreign write changed register");

    property p_enable;
        @(posedge MCLK) disable iff (!RST_N)
        s_wr_hit |=> CMP_ENABLE == $past(SFR_WDATA[cmpc_pkg::ENABLE_BIT]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit not loaded");

    // ------------------------------------------------------------
    // edge chain: level change, one-cycle pulse, then sticky flag
    // ------------------------------------------------------------
    sequence s_level_rise;
        $rose(cmp.level);
    endsequence

    sequence s_level_fall;
        $fell(cmp.level);
    endsequence

    // the pulse lags the level by one flop, the flag by one more
    property p_rise_chain;
        @(posedge MCLK) disable iff (!RST_N)
        s_level_rise |=> cmp.rise ##1 rise_flag;
    endproperty
    a_rise_chain: assert property (p_rise_chain) else $error("rising edge not flagged");

    // same timing on the falling side
    property p_fall_chain;
        @(posedge MCLK) disable iff (!RST_N)
        s_level_fall |=> cmp.fall ##1 fall_flag;
    endproperty
    a_fall_chain: assert property (p_fall_chain) else $error("falling edge not flagged");

    // a zero written with no coincident edge must clear the flag
    property p_rise_clear;
        @(posedge MCLK) disable iff (!RST_N)
        (s_wr_hit ##0 (!SFR_WDATA[cmpc_pkg::RISE_BIT] && !cmp.rise)) |=> !rise_flag;
    endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared");

    // falling flag clears the same way
    property p_fall_clear;
        @(posedge MCLK) disable iff (!RST_N)
        (s_wr_hit ##0 (!SFR_WDATA[cmpc_pkg::FALL_BIT] && !cmp.fall)) |=> !fall_flag;
    endproperty
    a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");

    // every software field returns on the bus as it stands in its flop
    property p_read_fields;
        @(posedge MCLK) disable iff (!RST_N)
        s_rd_hit |=> SFR_RDATA[cmpc_pkg::ENABLE_BIT] == $past(CMP_ENABLE)
                     && SFR_RDATA[cmpc_pkg::RISE_BIT] == $past(rise_flag)
                     && SFR_RDATA[cmpc_pkg::FALL_BIT] == $past(fall_flag)
                     && SFR_RDATA[cmpc_pkg::POS_HI:cmpc_pkg::POS_LO] == $past(CMP_POS_HYST)
                     && SFR_RDATA[cmpc_pkg::NEG_HI:cmpc_pkg::NEG_LO] == $past(CMP_NEG_HYST);
    endproperty
    a_read_fields: assert property (p_read_fields) else $error("read data field wrong");

    // a missed or absent read leaves zero on the bus, not stale data
    property p_idle_read;
        @(posedge MCLK) disable iff (!RST_N)
        !rd_hit |=> SFR_RDATA == 8'h00;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data not idle");

endmodule

`default_nettype wire

// ### tb/cmpc_tb.sv
// self-checking bench for the comparator control register
`timescale 1ns/1ns
`default_nettype none

module testbench;
    // ------------------------------------------------------------
    // stimulus, observed outputs and model state
    // ------------------------------------------------------------
    logic       MCLK  = 1'b0;
    logic       RST_N = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] page  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       cmp   = 1'b0;
    logic [7:0] rdata;
    logic       en;
    logic [1:0] pos;
    logic [1:0] neg;
    int         fails       = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    int         m_en, m_out, m_rise, m_fall, m_pos, m_neg;

    cmpc_control dut (
        .MCLK         (MCLK),
        .RST_N        (RST_N),
        .SFR_ADDR     (addr),
        .SFR_PAGE     (page),
        .SFR_WR       (wr),
        .SFR_RD       (rd),
        .SFR_WDATA    (wdata),
        .SFR_RDATA    (rdata),
        .CMP_RESULT   (cmp),
        .CMP_ENABLE   (en),
        .CMP_POS_HYST (pos),
        .CMP_NEG_HYST (neg)
    );

    // 20 MHz clock
    always #25 MCLK = ~MCLK;

    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] model_reg();
        return 8'((m_en << 7) | (m_out << 6) | (m_rise << 5) | (m_fall << 4)
                  | (m_pos << 2) | m_neg);
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe; outputs are settled the cycle after
    task automatic do_wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge MCLK);
        addr  <= a;
        page  <= p;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge MCLK);
        wr <= 1'b0;
        if (a == cmpc_pkg::CTRL_ADDR && p == cmpc_pkg::CTRL_PAGE) begin
            m_en   = d[7];
            m_rise = d[5];
            m_fall = d[4];
            m_pos  = d[3:2];
            m_neg  = d[1:0];
        end
        #1;
        chk("enable", 8'(m_en), {7'h00, en});
        chk("hysteresis", 8'((m_pos << 2) | m_neg), {4'h0, pos, neg});
    endtask

    // read data arrives exactly one cycle after the strobe
    task automatic do_rd(input logic [7:0] a, input logic [7:0] p);
        @(posedge MCLK);
        addr <= a;
        page <= p;
        rd   <= 1'b1;
        @(posedge MCLK);
        rd <= 1'b0;
        #1;
        chk("rdata", (a == cmpc_pkg::CTRL_ADDR && p == cmpc_pkg::CTRL_PAGE) ? model_reg() : 8'h00, rdata);
    endtask

    // five cycles covers the two-flop synchroniser plus the flag update
    task automatic set_cmp(input logic v);
        @(posedge MCLK);
        cmp <= v;
        repeat (5) @(posedge MCLK);
        if (v && m_out == 0) m_rise = 1;
        if (!v && m_out == 1) m_fall = 1;
        m_out = v;
    endtask

    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h4528));
        {m_en, m_out, m_rise, m_fall, m_pos, m_neg} = '0;
        repeat (10) @(posedge MCLK);
        RST_N <= 1'b1;
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        $display("test reset done");
        // every hysteresis pair, bit 6 written high must not stick
        for (int i = 0; i < 16; i++) begin
            do_wr(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE, {i[0], 1'b1, 2'b00, i[3:0]});
            do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        end
        $display("test hysteresis done");
        set_cmp(1'b1);
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        set_cmp(1'b0);
        set_cmp(1'b1);
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        do_wr(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE, 8'h80);
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        $display("test edge flags done");
        // wrong address and wrong page are ignored
        do_wr(8'h9b, cmpc_pkg::CTRL_PAGE, 8'hff);
        do_rd(8'h9b, cmpc_pkg::CTRL_PAGE);
        do_wr(cmpc_pkg::CTRL_ADDR, 8'h01, 8'hff);
        do_rd(cmpc_pkg::CTRL_ADDR, 8'h01);
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        $display("test decode done");
        for (int i = 0; i < 40; i++) begin
            do_wr(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE, 8'($urandom));
            set_cmp(1'($urandom));
            do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        end
        $display("test random done");
        // mid-run reset with every field set; input parked low first
        do_wr(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE, 8'hff);
        set_cmp(1'b0);
        @(posedge MCLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge MCLK);
        RST_N <= 1'b1;
        {m_en, m_out, m_rise, m_fall, m_pos, m_neg} = '0;
        #1;
        chk("reset outputs", 8'h00, {3'h0, en, pos, neg});
        do_rd(cmpc_pkg::CTRL_ADDR, cmpc_pkg::CTRL_PAGE);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule

`default_nettype wire
